// File: inc/stop_seq_pkg.sv
// constants and types of the stop sequence selection
package stop_seq_pkg;

    // *************************************************
    // setting encodings and defaults
    // *************************************************
    localparam logic [1:0]  OT_MODE_DIR      = 2'h0;    // limits inhibit own way
    localparam logic [1:0]  OT_MODE_IGNORE   = 2'h1;    // limits ignored (default)
    localparam logic [1:0]  OT_MODE_ERROR    = 2'h2;    // limits raise an error
    localparam logic [1:0]  OT_SEQ_DEFAULT   = 2'h0;
    localparam logic [1:0]  OT_SEQ_MAX       = 2'h2;
    localparam logic [1:0]  OT_SEQ_ESTOP     = 2'h2;
    localparam logic [1:0]  OT_SEQ_ZEROTQ    = 2'h1;
    localparam logic [3:0]  SEQ_DEFAULT      = 4'h0;    // servo-off/power-loss
    localparam logic [3:0]  SEQ_MAX          = 4'h9;
    localparam logic [3:0]  SEQ_HOLD_LO      = 4'h4;
    localparam logic [3:0]  SEQ_HOLD_HI      = 4'h7;
    localparam logic [3:0]  SEQ_ESTOP_DB     = 4'h8;
    localparam logic [3:0]  SEQ_ESTOP_FREE   = 4'h9;
    localparam logic [2:0]  ALARM_ESTOP_LO   = 3'h4;    // alarm estop range start
    localparam int          SEQ_DECEL_BIT    = 0;       // bit 0 set: free-run while decelerating
    localparam int          SEQ_AFTER_BIT    = 1;       // bit 1 set: free-run after stop
    localparam logic        UV_TRIP_DEFAULT  = 1'b1;

    // *************************************************
    // detection time and speed figures
    // *************************************************
    localparam logic [10:0] DETECT_MIN       = 11'h046;  // 70 ms, also the default
    localparam logic [10:0] DETECT_MAX       = 11'h7D0;  // 2000 ms, detection disabled
    localparam logic [10:0] DETECT_NO_UV     = 11'h3E8;  // 1000 ms, trip selection ignored
    localparam int          CLOCK_MHZ        = 125;
    localparam int          DETECT_STEP_US   = 1000;     // one detection step
    localparam int          CYCLES_PER_MS    = CLOCK_MHZ * DETECT_STEP_US;
    localparam logic [15:0] STOP_SPEED_RPM   = 16'h001E; // 30 r/min ends deceleration

    // *************************************************
    // braking action driven to the power stage
    // *************************************************
    typedef enum logic [1:0] {
        ACT_RUN,
        ACT_DBRAKE,
        ACT_FREE,
        ACT_ESTOP
    } brake_act_t;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_OVERTRAVEL,
        CAUSE_SERVO_OFF,
        CAUSE_POWER_LOSS,
        CAUSE_ALARM
    } stop_cause_t;

endpackage

// File: hw/ms_ticker.sv
// millisecond tick generator from the control clock
`timescale 1ns/10ps
`default_nettype none
module ms_ticker #(
    parameter int unsigned CYCLES = 125000
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic enable,
    output logic      tick
);
    logic [16:0] count;

    // free-running divider, one tick per ms
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (enable) begin
            if (count == 17'(CYCLES - 1)) begin
                count <= '0;
                tick  <= 1'b1;
            end else begin
                count <= count + 17'h00001;
                tick  <= 1'b0;
            end
        end
    end
endmodule // ms_ticker
`default_nettype wire

// File: hw/seq_decode.sv
// decoder of the ten-way servo-off / power-loss sequence setting
`timescale 1ns/10ps
`default_nettype none
module seq_decode (
    input  wire logic [3:0] setting,
    output logic            decelFree,
    output logic            afterFree,
    output logic            decelEstop,
    output logic            clearDev
);
    import stop_seq_pkg::*;
    logic [3:0] sel;

    // out-of-range settings act as default
    always_comb begin
        sel        = (setting > SEQ_MAX) ? SEQ_DEFAULT : setting;
        decelEstop = (sel == SEQ_ESTOP_DB) || (sel == SEQ_ESTOP_FREE);
        decelFree  = !decelEstop && sel[SEQ_DECEL_BIT];
        afterFree  = decelEstop ? (sel == SEQ_ESTOP_FREE) : sel[SEQ_AFTER_BIT];
        clearDev   = !((sel >= SEQ_HOLD_LO) && (sel <= SEQ_HOLD_HI));
    end
endmodule // seq_decode
`default_nettype wire

// File: hw/servo_stop_sequence_select.sv
// stop sequence selection: over-travel, servo-off, main power loss and alarm
// Operation
// - mode 0 limits inhibit own direction, mode 1 ignores, default 1
// - mode 2: any limit input raises the limit input error
// - over-travel sequence 0..2, default 0, used only in mode 0
// - over-travel: zero torque inhibited way; DB/zero/estop decel; 2 clears deviation
// - servo-off sequence 0..9 picks brake/free-run and clear/hold deviation
// - a clearing sequence drives the deviation to zero
// - held deviation keeps accumulating; excess raises the excess deviation error
// - emergency stop runs with servo on, torque capped by its limit setting
// - deceleration ends below 30 r/min; afterwards treated as stopped
// - error during servo-off follows the alarm sequence
// - power loss during servo-off follows the power-loss sequence
// - power-loss sequence 0..9, default 0, same encoding as servo-off
// - error while main power is off follows the alarm sequence
// - trip select 1: loss at servo-on trips undervoltage, alarm sequence
// - trip select 0: no error, servo off, auto servo-on after restore
// - loss recognised only after lasting the detection time continuously
// - trip selection ignored when detection time equals 1000
// - bus voltage low before detection raises undervoltage error always
// - detection time 70..2000 ms steps, 2000 disables detection
// - mode, over-travel sequence, detection time latched at control power-on
// - alarm sequence 0..7 selects decel and after-stop behaviour
// - alarm 4..7: estop if alarm needs it; deviation held, cleared on cancel
`timescale 1ns/10ps
`default_nettype none
module servo_stop_sequence_select (
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire logic                      clockEnable,
    input  wire logic                      servoOnRequest,
    input  wire logic                      positive_limit_input,
    input  wire logic                      negativeLimitInput,
    input  wire logic                      mainPowerPresent,
    input  wire logic                      busVoltageLow,
    input  wire logic                      alarmActive,
    input  wire logic                      alarmNeedsEstop,
    input  wire logic                      alarmClear,
    input  wire logic                      deviationExcess,
    input  wire logic [15:0]               motorSpeed,
    input  wire logic [1:0]                overtravel_mode,
    input  wire logic [1:0]                overtravel_stop_sequence,
    input  wire logic [3:0]                servo_off_sequence,
    input  wire logic [3:0]                power_loss_sequence,
    input  wire logic                      undervoltage_trip_select,
    input  wire logic [10:0]               power_loss_detect_time,
    input  wire logic [2:0]                alarm_stop_sequence,
    input  wire logic [9:0]                emergency_torque_limit,
    output stop_seq_pkg::brake_act_t       brakeAction,
    output stop_seq_pkg::stop_cause_t      stopCause,
    output logic                           servoEnergized,
    output logic                           dynamic_brake,
    output logic                           inhibitPositive,
    output logic                           inhibitNegative,
    output logic                           clearDeviation,
    output logic                           estopTorqueActive,
    output logic [9:0]                     estopTorqueLimit,
    output logic                           limit_input_error,
    output logic                           main_undervoltage_error,
    output logic                           excess_deviation_error,
    output logic                           powerLossDetected
);
    import stop_seq_pkg::*;

    // *************************************************
    // settings latched at control power-on
    // *************************************************
    logic [1:0]  otMode;
    logic [1:0]  otSeq;
    logic [10:0] detectTime;
    logic        latched;

    // capture once after reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latched    <= 1'b0;
            otMode     <= OT_MODE_IGNORE;
            otSeq      <= OT_SEQ_DEFAULT;
            detectTime <= DETECT_MIN;
        end else if (clockEnable && !latched) begin
            latched    <= 1'b1;
            otMode     <= (overtravel_mode > OT_MODE_ERROR) ? OT_MODE_IGNORE
                                                            : overtravel_mode;
            otSeq      <= (overtravel_stop_sequence > OT_SEQ_MAX) ? OT_SEQ_DEFAULT
                                                                  : overtravel_stop_sequence;
            detectTime <= (power_loss_detect_time < DETECT_MIN ||
                           power_loss_detect_time > DETECT_MAX) ? DETECT_MIN
                                                                : power_loss_detect_time;
        end
    end

    // *************************************************
    // sequence decoders
    // *************************************************
    logic soDecelFree, soAfterFree, soEstop, soClear;
    logic plDecelFree, plAfterFree, plEstop, plClear;

    seq_decode servoOffDecode (
        .setting    (servo_off_sequence),
        .decelFree  (soDecelFree),
        .afterFree  (soAfterFree),
        .decelEstop (soEstop),
        .clearDev   (soClear)
    );

    seq_decode powerLossDecode (
        .setting    (power_loss_sequence),
        .decelFree  (plDecelFree),
        .afterFree  (plAfterFree),
        .decelEstop (plEstop),
        .clearDev   (plClear)
    );

    // *************************************************
    // main power loss detection
    // *************************************************
    logic        msTick;
    logic [10:0] lossMs;

    ms_ticker #(
        .CYCLES (CYCLES_PER_MS)
    ) lossTicker (
        .clock  (clock),
        .nrst   (nrst),
        .enable (clockEnable),
        .tick   (msTick)
    );

    // continuous loss time; power return restarts it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lossMs            <= '0;
            powerLossDetected <= 1'b0;
        end else if (clockEnable) begin
            if (mainPowerPresent || detectTime == DETECT_MAX) begin
                lossMs            <= '0;
                powerLossDetected <= 1'b0;
            end else begin
                if (msTick && lossMs != DETECT_MAX)
                    lossMs <= lossMs + 11'h001;
                if (lossMs >= detectTime)
                    powerLossDetected <= 1'b1;
            end
        end
    end

    // *************************************************
    // stop speed and alarm sequence decode
    // *************************************************
    logic       stopped;
    logic [2:0] alSel;
    logic       alarmEstop;
    logic       alDecelFree;
    logic       alAfterFree;
    logic       uvTripArmed;

    // below 30 r/min counts as stopped
    always_comb begin
        stopped     = motorSpeed < STOP_SPEED_RPM;
        alSel       = alarm_stop_sequence;
        alarmEstop  = (alSel >= ALARM_ESTOP_LO) && alarmNeedsEstop;
        alDecelFree = alSel[SEQ_DECEL_BIT];
        alAfterFree = alSel[SEQ_AFTER_BIT];
        uvTripArmed = undervoltage_trip_select || detectTime == DETECT_NO_UV;
    end

    // *************************************************
    // error flags
    // *************************************************
    logic anyLimit;
    assign anyLimit = positive_limit_input || negativeLimitInput;

    // errors are sticky until alarm clear; a new cause in the clear cycle wins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            limit_input_error       <= 1'b0;
            main_undervoltage_error <= 1'b0;
            excess_deviation_error  <= 1'b0;
        end else if (clockEnable) begin
            limit_input_error <= (otMode == OT_MODE_ERROR && anyLimit) ||
                                 (limit_input_error && !alarmClear);
            main_undervoltage_error <=
                (busVoltageLow && !powerLossDetected) ||
                (powerLossDetected && servoEnergized && uvTripArmed) ||
                (main_undervoltage_error && !alarmClear);
            excess_deviation_error <= deviationExcess ||
                                      (excess_deviation_error && !alarmClear);
        end
    end

    // *************************************************
    // stop cause arbitration
    // *************************************************
    logic        anyError;
    logic        otHitPos;
    logic        otHitNeg;
    stop_cause_t next_cause;

    // alarms outrank power loss, which outranks plain servo-off
    always_comb begin
        anyError   = alarmActive || limit_input_error ||
                     main_undervoltage_error || excess_deviation_error;
        otHitPos   = (otMode == OT_MODE_DIR) && positive_limit_input;
        otHitNeg   = (otMode == OT_MODE_DIR) && negativeLimitInput;
        if (anyError)
            next_cause = CAUSE_ALARM;
        else if (powerLossDetected)
            next_cause = CAUSE_POWER_LOSS;
        else if (!servoOnRequest)
            next_cause = CAUSE_SERVO_OFF;
        else if (otHitPos || otHitNeg)
            next_cause = CAUSE_OVERTRAVEL;
        else
            next_cause = CAUSE_NONE;
    end

    // *************************************************
    // braking action selection
    // *************************************************
    brake_act_t next_action;
    logic       next_clear;
    logic       next_inhPos;
    logic       next_inhNeg;

    always_comb begin
        next_action = ACT_RUN;
        next_clear  = 1'b0;
        next_inhPos = 1'b0;
        next_inhNeg = 1'b0;
        case (next_cause)
            CAUSE_OVERTRAVEL: begin
                next_inhPos = otHitPos;
                next_inhNeg = otHitNeg;
                if (stopped)
                    next_action = ACT_RUN;                          // zero torque one way
                else if (otSeq == OT_SEQ_ESTOP)
                    next_action = ACT_ESTOP;
                else if (otSeq == OT_SEQ_ZEROTQ)
                    next_action = ACT_RUN;
                else
                    next_action = ACT_DBRAKE;
                next_clear = (otSeq == OT_SEQ_ESTOP);
            end
            CAUSE_SERVO_OFF: begin
                if (!stopped)
                    next_action = soEstop ? ACT_ESTOP :
                                  (soDecelFree ? ACT_FREE : ACT_DBRAKE);
                else
                    next_action = soAfterFree ? ACT_FREE : ACT_DBRAKE;
                next_clear = soClear;
            end
            CAUSE_POWER_LOSS: begin
                if (!stopped)
                    next_action = plEstop ? ACT_ESTOP :
                                  (plDecelFree ? ACT_FREE : ACT_DBRAKE);
                else
                    next_action = plAfterFree ? ACT_FREE : ACT_DBRAKE;
                next_clear = plClear;
            end
            CAUSE_ALARM: begin
                if (!stopped)
                    next_action = alarmEstop ? ACT_ESTOP :
                                  (alDecelFree ? ACT_FREE : ACT_DBRAKE);
                else
                    next_action = alAfterFree ? ACT_FREE : ACT_DBRAKE;
                next_clear = alarmClear;
            end
            default: begin
                next_action = ACT_RUN;
            end
        endcase
    end

    // *************************************************
    // registered outputs
    // *************************************************
    // power stage outputs are registered so the stage sees glitch-free levels
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            brakeAction       <= ACT_DBRAKE;
            stopCause         <= CAUSE_NONE;
            servoEnergized    <= 1'b0;
            dynamic_brake     <= 1'b1;
            inhibitPositive   <= 1'b0;
            inhibitNegative   <= 1'b0;
            clearDeviation    <= 1'b0;
            estopTorqueActive <= 1'b0;
            estopTorqueLimit  <= '0;
        end else if (clockEnable) begin
            brakeAction       <= next_action;
            stopCause         <= next_cause;
            // estop and zero torque keep the servo energised
            servoEnergized    <= (next_action == ACT_RUN) ||
                                 (next_action == ACT_ESTOP);
            dynamic_brake     <= (next_action == ACT_DBRAKE);
            inhibitPositive   <= next_inhPos;
            inhibitNegative   <= next_inhNeg;
            clearDeviation    <= next_clear;
            estopTorqueActive <= (next_action == ACT_ESTOP);
            estopTorqueLimit  <= emergency_torque_limit;
        end
    end
endmodule // servo_stop_sequence_select
`default_nettype wire

// File: verif/servo_stop_sequence_select_properties.sv
// property checker for the stop sequence selection block
`timescale 1ns/10ps
`default_nettype none
module stop_seq_checker (
    input wire logic                      clock,
    input wire logic                      nrst,
    input wire logic                      clockEnable,
    input wire logic                      servoOnRequest,
    input wire logic                      positive_limit_input,
    input wire logic                      negativeLimitInput,
    input wire logic                      mainPowerPresent,
    input wire logic                      busVoltageLow,
    input wire logic                      alarmActive,
    input wire logic                      alarmNeedsEstop,
    input wire logic                      deviationExcess,
    input wire logic [15:0]               motorSpeed,
    input wire logic [1:0]                overtravel_mode,
    input wire logic [3:0]                servo_off_sequence,
    input wire logic [2:0]                alarm_stop_sequence,
    input wire stop_seq_pkg::brake_act_t  brakeAction,
    input wire stop_seq_pkg::stop_cause_t stopCause,
    input wire logic                      servoEnergized,
    input wire logic                      inhibitPositive,
    input wire logic                      clearDeviation,
    input wire logic                      estopTorqueActive,
    input wire logic                      limit_input_error,
    input wire logic                      main_undervoltage_error,
    input wire logic                      excess_deviation_error
);
    import stop_seq_pkg::*;
    logic       quiet;
    logic [1:0] calm;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // errors reach the brake a cycle late; wait for calm
    assign quiet = clockEnable && !alarmActive && mainPowerPresent && !busVoltageLow
        && !limit_input_error && !main_undervoltage_error && !excess_deviation_error;
    // saturating calm count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            calm <= 2'h0;
        end else begin
            calm <= !quiet ? 2'h0 : (calm == 2'h3 ? calm : calm + 2'h1);
        end
    end
    property p_limit_error;
        clockEnable && overtravel_mode == OT_MODE_ERROR
            && (positive_limit_input || negativeLimitInput) |=> limit_input_error;
    endproperty
    a_limit_error: assert property (p_limit_error) else $error("limit error missing");
    property p_limit_ignore;
        overtravel_mode == OT_MODE_IGNORE |=> !inhibitPositive;
    endproperty
    a_limit_ignore: assert property (p_limit_ignore) else $error("limit not ignored");
    property p_bus_low;
        clockEnable && busVoltageLow |=> main_undervoltage_error;
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("undervoltage missing");
    property p_excess;
        clockEnable && deviationExcess |=> excess_deviation_error;
    endproperty
    a_excess: assert property (p_excess) else $error("excess error missing");
    property p_clear;
        calm == 2'h3 && quiet && !servoOnRequest
            && !(servo_off_sequence inside {[SEQ_HOLD_LO:SEQ_HOLD_HI]})
            |=> clearDeviation && stopCause == CAUSE_SERVO_OFF && !servoEnergized == (brakeAction != ACT_ESTOP);
    endproperty
    a_clear: assert property (p_clear) else $error("servo-off clear wrong");
    property p_hold;
        calm == 2'h3 && quiet && !servoOnRequest
            && servo_off_sequence inside {[SEQ_HOLD_LO:SEQ_HOLD_HI]} |=> !clearDeviation;
    endproperty
    a_hold: assert property (p_hold) else $error("deviation not held");
    property p_estop_on;
        brakeAction == ACT_ESTOP |-> servoEnergized && estopTorqueActive;
    endproperty
    a_estop_on: assert property (p_estop_on) else $error("estop without servo");
    property p_alarm_estop;
        clockEnable && alarmActive && alarmNeedsEstop && alarm_stop_sequence >= ALARM_ESTOP_LO
            && motorSpeed >= 16'h0028 |-> ##[1:2] brakeAction == ACT_ESTOP;
    endproperty
    a_alarm_estop: assert property (p_alarm_estop) else $error("alarm estop missing");
endmodule // stop_seq_checker
bind servo_stop_sequence_select stop_seq_checker u_checker (.*);
`default_nettype wire

// File: verif/motor_stage_model.sv
// motor and power stage model: shaft speed seen by the stop logic
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model (
    input  wire logic                     clock,
    input  wire logic                     nrst,
    input  wire logic [15:0]              target,
    input  wire stop_seq_pkg::brake_act_t brakeAction,
    output logic [15:0]                   motorSpeed
);
    import stop_seq_pkg::*;
    // driven: jump to target; else slow one step a cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            motorSpeed <= 16'h0000;
        end else if (brakeAction == ACT_RUN) begin
            motorSpeed <= target;
        end else if (motorSpeed != 16'h0000) begin
            motorSpeed <= motorSpeed - 16'h0001;
        end
    end
endmodule // motor_stage_model
`default_nettype wire

// File: verif/servo_stop_sequence_select_bench.sv
// self-checking bench for the stop sequence selection block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        testsRun++; \
        if ((got) !== (exp)) begin \
            nErrors++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module servo_stop_sequence_select_bench;
    import stop_seq_pkg::*;
    logic        clock, nrst, clockEnable, servoOnRequest, positive_limit_input;
    logic        negativeLimitInput, mainPowerPresent, busVoltageLow, alarmActive;
    logic        alarmNeedsEstop, alarmClear, deviationExcess, undervoltage_trip_select;
    logic        servoEnergized, dynamic_brake, inhibitPositive, inhibitNegative;
    logic        clearDeviation, estopTorqueActive, limit_input_error, powerLossDetected;
    logic        main_undervoltage_error, excess_deviation_error;
    logic [15:0] motorSpeed, target, sp;
    logic [1:0]  overtravel_mode, overtravel_stop_sequence;
    logic [3:0]  servo_off_sequence, power_loss_sequence;
    logic [10:0] power_loss_detect_time;
    logic [2:0]  alarm_stop_sequence;
    logic [9:0]  emergency_torque_limit, estopTorqueLimit;
    brake_act_t  brakeAction;
    stop_cause_t stopCause;
    int          nErrors, testsRun, seed, k;
    servo_stop_sequence_select u_dut (.*);
    motor_stage_model u_motor (.*);
    // free-running control clock
    always #4 clock = ~clock;
    function automatic brake_act_t expAct(input logic est, fd, fa, input logic [15:0] s);
        if (s >= STOP_SPEED_RPM) return est ? ACT_ESTOP : (fd ? ACT_FREE : ACT_DBRAKE);
        return fa ? ACT_FREE : ACT_DBRAKE;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // latched settings need a fresh reset
    task automatic restart(input logic [1:0] mode);
        @(posedge clock);
        nrst <= 1'b0;
        overtravel_mode <= mode;
        overtravel_stop_sequence <= OT_SEQ_ESTOP;
        cyc(16);
        nrst <= 1'b1;
        servoOnRequest <= 1'b1;
        target <= 16'h0028;
        cyc(4);
    endtask
    // skip speeds near 30 r/min
    task automatic watch(input logic est, fd, fa, clr, input int n);
        repeat (n) begin
            @(posedge clock);
            sp = motorSpeed;
            #1;
            if (sp < 16'h001C || sp > 16'h0020) begin
                `CHECK(brakeAction, expAct(est, fd, fa, sp))
                `CHECK(clearDeviation, clr)
                `CHECK(dynamic_brake, brakeAction == ACT_DBRAKE)
            end
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // over-travel, servo-off, alarm, errors, power loss
    initial begin
        {clock, nrst, nErrors, testsRun, seed} = {2'h0, 32'h0, 32'h0, 32'hCFCB1023};
        {clockEnable, mainPowerPresent, undervoltage_trip_select} = 3'h7;
        {servoOnRequest, positive_limit_input, negativeLimitInput, busVoltageLow} = 4'h0;
        {alarmActive, alarmNeedsEstop, alarmClear, deviationExcess} = 4'h0;
        {servo_off_sequence, power_loss_sequence, alarm_stop_sequence} = 11'h000;
        {emergency_torque_limit, target} = 26'h0;
        power_loss_detect_time = DETECT_MIN;
        overtravel_mode = OT_MODE_IGNORE;
        overtravel_stop_sequence = OT_SEQ_DEFAULT;
        for (int m = 0; m < 3; m++) begin
            restart(m[1:0]);
            overtravel_stop_sequence <= OT_SEQ_DEFAULT;
            positive_limit_input <= 1'b1;
            cyc(3);
            if (m < 2) `CHECK(brakeAction, m == 0 ? ACT_ESTOP : ACT_RUN)
            `CHECK(clearDeviation, m == 0)
            `CHECK(limit_input_error, m == 2)
            target <= 16'h0000;
            cyc(40);
            `CHECK({inhibitPositive, inhibitNegative}, {m == 0, 1'b0})
            positive_limit_input <= 1'b0;
            alarmClear <= 1'b1;
            cyc(1);
            alarmClear <= 1'b0;
        end
        restart(OT_MODE_IGNORE);
        clockEnable <= 1'b0;
        servoOnRequest <= 1'b0;
        cyc(4);
        `CHECK(servoEnergized, 1'b1)
        clockEnable <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            @(posedge clock);
            servo_off_sequence <= s[3:0];
            servoOnRequest <= 1'b1;
            target <= 16'h0028 + 16'($random(seed) & 31);
            cyc(3);
            servoOnRequest <= 1'b0;
            k = (s > 9) ? 0 : s;
            watch(k >= 8, k[0], k == 9 || (k < 8 && k[1]), k < 4 || k >= 8, 50);
            `CHECK(stopCause, CAUSE_SERVO_OFF)
        end
        for (int a = 0; a < 8; a++) begin
            @(posedge clock);
            alarm_stop_sequence <= a[2:0];
            alarmNeedsEstop <= (a == 5 || a == 7) || 1'($random(seed));
            emergency_torque_limit <= 10'($random(seed));
            servoOnRequest <= 1'b1;
            target <= 16'h0040;
            cyc(3);
            alarmActive <= 1'b1;
            servoOnRequest <= 1'($random(seed));
            cyc(1);
            watch(a >= 4 && alarmNeedsEstop, a[0], a[1], 1'b0, 50);
            `CHECK(stopCause, CAUSE_ALARM)
            `CHECK(estopTorqueLimit, emergency_torque_limit)
            @(posedge clock);
            alarmActive <= 1'b0;
            alarmClear <= 1'b1;
            @(posedge clock);
            alarmClear <= 1'b0;
            servoOnRequest <= 1'b1;
        end
        {busVoltageLow, deviationExcess} <= 2'h3;
        cyc(1);
        {busVoltageLow, deviationExcess} <= 2'h0;
        cyc(4);
        `CHECK({main_undervoltage_error, excess_deviation_error}, 2'h3)
        alarmClear <= 1'b1;
        cyc(1);
        alarmClear <= 1'b0;
        cyc(3);
        `CHECK({main_undervoltage_error, excess_deviation_error}, 2'h0)
        mainPowerPresent <= 1'b0;
        cyc(300);
        `CHECK({powerLossDetected, main_undervoltage_error, servoEnergized}, 3'h1)
        mainPowerPresent <= 1'b1;
        cyc(4);
        conclude();
    end
endmodule // servo_stop_sequence_select_bench
`default_nettype wire
